// file: rtl/sirq_regs.sv
// Chosen here: strobed register access.
`timescale 1ns/100ps
// Overview of operation
// - enable byte 00h: bits 5,4,1,0; 01h empty
// - watchdog enable gates only in interval mode
// - bit 5 enables flash violation request
// - flag byte 02h bits 4..0; 03h empty
// - watchdog flag set by reset-mode overflow or key violation
// - watchdog flag cleared by power-on or pin reset
// - plain reset bits reload on program reset
// - parenthesised bits reload on power-on only; the watchdog flag also on pin reset
// - unused bits read zero, ignore writes
module sirq_regs
    import sirq_pkg::*;
(
    // clock and resets
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic PROGRAM_RESET_IN,
    input wire logic POWER_ON_IN,
    input wire logic EXT_PIN_RESET_IN,
    // register port
    input wire logic [sirq_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [sirq_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [sirq_pkg::DATA_W-1:0] RDATA_OUT,
    // events
    input wire logic WDOG_MODE_IN,
    input wire logic WDOG_OVERFLOW_IN,
    input wire logic WDOG_INTERVAL_IN,
    input wire logic KEY_VIOLATION_IN,
    input wire logic OSC_FAULT_IN,
    input wire logic PIN_NMI_IN,
    input wire logic FLASH_VIOLATION_IN,
    // requests
    output logic WDOG_IRQ_OUT,
    output logic NMI_IRQ_OUT
);
    import sirq_pkg::*;

    // program reset covers the power-on case as well
    logic prog_rst;
    logic por_like;
    logic wr_en;
    logic wr_fl;
    logic watchdog_irq_en_reg;
    logic osc_fault_irq_en_reg;
    logic pin_nmi_irq_en_reg;
    logic flash_violation_irq_en_reg;
    logic watchdog_flag_reg;
    logic power_on_flag_reg;
    logic ext_reset_flag_reg;
    logic osc_fault_flag;
    logic pin_nmi_flag;
    logic wdog_set;
    logic wdog_reset_mode;
    logic wdog_interval_mode;
    logic nmi_pin_req;
    logic nmi_osc_req;
    logic nmi_flash_req;
    logic wdog_irq_next;
    logic nmi_irq_next;
    logic [DATA_W-1:0] en_byte;
    logic [DATA_W-1:0] fl_byte;
    logic [DATA_W-1:0] rdata_next;

    assign prog_rst = RST_IN | PROGRAM_RESET_IN | POWER_ON_IN;
    assign por_like = RST_IN | POWER_ON_IN;

    // writes reach storage only at the two low byte offsets
    assign wr_en = WR_IN & (ADDR_IN == SIRQ_EN_LO_ADDR);
    assign wr_fl = WR_IN & (ADDR_IN == SIRQ_FLAG_LO_ADDR);

    // the reset-mode decode feeds the flag set; the interval-mode decode feeds the request gate
    assign wdog_reset_mode = (WDOG_MODE_IN == SIRQ_WDOG_RESET);
    assign wdog_interval_mode = (WDOG_MODE_IN == SIRQ_WDOG_INTERVAL);

    // enables clear on every program reset, power-on included
    always_ff @(posedge MCLK_IN) begin
        if (prog_rst) begin
            watchdog_irq_en_reg <= EN_RST_VAL;
            osc_fault_irq_en_reg <= EN_RST_VAL;
            pin_nmi_irq_en_reg <= EN_RST_VAL;
            flash_violation_irq_en_reg <= EN_RST_VAL;
        end else if (wr_en) begin
            watchdog_irq_en_reg <= WDATA_IN[EN_WDOG_BIT];
            osc_fault_irq_en_reg <= WDATA_IN[EN_OSC_BIT];
            pin_nmi_irq_en_reg <= WDATA_IN[EN_NMI_BIT];
            flash_violation_irq_en_reg <= WDATA_IN[EN_FLASH_BIT];
        end
    end

    assign wdog_set = (WDOG_OVERFLOW_IN & wdog_reset_mode)
                      | KEY_VIOLATION_IN;

    // watchdog flag survives PROGRAM_RESET_IN; set beats a flag-byte write, power-on or pin reset beats set
    always_ff @(posedge MCLK_IN) begin
        if (por_like | EXT_PIN_RESET_IN) begin
            watchdog_flag_reg <= FL_WDOG_POR_VAL;
        end else if (wdog_set) begin
            watchdog_flag_reg <= 1'b1;
        end else if (wr_fl) begin
            watchdog_flag_reg <= WDATA_IN[FL_WDOG_BIT];
        end
    end

    // cold-start marker; software clears it to spot later resets
    always_ff @(posedge MCLK_IN) begin
        if (por_like) begin
            power_on_flag_reg <= FL_POR_POR_VAL;
        end else if (wr_fl) begin
            power_on_flag_reg <= WDATA_IN[FL_POR_BIT];
        end
    end

    // pin reset sets the cause flag; power-on or a flag-byte write clears it
    always_ff @(posedge MCLK_IN) begin
        if (por_like) begin
            ext_reset_flag_reg <= FL_EXT_POR_VAL;
        end else if (EXT_PIN_RESET_IN) begin
            ext_reset_flag_reg <= 1'b1;
        end else if (wr_fl) begin
            ext_reset_flag_reg <= WDATA_IN[FL_EXT_BIT];
        end
    end

    // oscillator and pin flags reload on every program reset
    sirq_flag_bit #(.RST_VAL(FL_OSC_PRST_VAL)) u_osc_flag (
        .clk_in(MCLK_IN),
        .rst_in(prog_rst),
        .set_in(OSC_FAULT_IN),
        .wr_in(wr_fl),
        .wdata_in(WDATA_IN[FL_OSC_BIT]),
        .q_out(osc_fault_flag)
    );

    sirq_flag_bit #(.RST_VAL(FL_NMI_PRST_VAL)) u_nmi_flag (
        .clk_in(MCLK_IN),
        .rst_in(prog_rst),
        .set_in(PIN_NMI_IN),
        .wr_in(wr_fl),
        .wdata_in(WDATA_IN[FL_NMI_BIT]),
        .q_out(pin_nmi_flag)
    );

    // every NMI source is gated only by its own enable
    assign nmi_pin_req = pin_nmi_flag & pin_nmi_irq_en_reg;
    assign nmi_osc_req = osc_fault_flag & osc_fault_irq_en_reg;
    assign nmi_flash_req = FLASH_VIOLATION_IN &
                           flash_violation_irq_en_reg;

    // reset mode makes the watchdog a reset source, not an interrupt
    always_comb begin
        wdog_irq_next = 1'b0;
        if (wdog_interval_mode) begin
            wdog_irq_next = WDOG_INTERVAL_IN & watchdog_irq_en_reg;
        end
    end

    assign nmi_irq_next = nmi_pin_req | nmi_osc_req | nmi_flash_req;

    always_ff @(posedge MCLK_IN) begin
        if (prog_rst) begin
            WDOG_IRQ_OUT <= 1'b0;
        end else begin
            WDOG_IRQ_OUT <= wdog_irq_next;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (prog_rst) begin
            NMI_IRQ_OUT <= 1'b0;
        end else begin
            NMI_IRQ_OUT <= nmi_irq_next;
        end
    end

    // packed images of the implemented bytes; absent bits stay zero
    always_comb begin
        en_byte = SIRQ_ZERO_BYTE;
        en_byte[EN_WDOG_BIT] = watchdog_irq_en_reg;
        en_byte[EN_OSC_BIT] = osc_fault_irq_en_reg;
        en_byte[EN_NMI_BIT] = pin_nmi_irq_en_reg;
        en_byte[EN_FLASH_BIT] = flash_violation_irq_en_reg;
    end

    always_comb begin
        fl_byte = SIRQ_ZERO_BYTE;
        fl_byte[FL_WDOG_BIT] = watchdog_flag_reg;
        fl_byte[FL_OSC_BIT] = osc_fault_flag;
        fl_byte[FL_POR_BIT] = power_on_flag_reg;
        fl_byte[FL_EXT_BIT] = ext_reset_flag_reg;
        fl_byte[FL_NMI_BIT] = pin_nmi_flag;
    end

    // the high byte of each pair falls to the zero default
    always_comb begin
        rdata_next = SIRQ_ZERO_BYTE;
        case (ADDR_IN)
            SIRQ_EN_LO_ADDR: begin
                rdata_next = en_byte;
            end
            SIRQ_FLAG_LO_ADDR: begin
                rdata_next = fl_byte;
            end
            default: begin
                rdata_next = SIRQ_ZERO_BYTE;
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= SIRQ_ZERO_BYTE;
        end else if (RD_IN) begin
            RDATA_OUT <= rdata_next;
        end else begin
            RDATA_OUT <= SIRQ_ZERO_BYTE;
        end
    end
endmodule

// file: include/sirq_pkg.sv
package sirq_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets (byte addresses)
    localparam logic [7:0] SIRQ_EN_LO_ADDR = 8'h00;
    localparam logic [7:0] SIRQ_EN_HI_ADDR = 8'h01;
    localparam logic [7:0] SIRQ_FLAG_LO_ADDR = 8'h02;
    localparam logic [7:0] SIRQ_FLAG_HI_ADDR = 8'h03;

    // enable byte fields
    localparam int EN_WDOG_BIT = 0;
    localparam int EN_OSC_BIT = 1;
    localparam int EN_NMI_BIT = 4;
    localparam int EN_FLASH_BIT = 5;

    // flag byte fields
    localparam int FL_WDOG_BIT = 0;
    localparam int FL_OSC_BIT = 1;
    localparam int FL_POR_BIT = 2;
    localparam int FL_EXT_BIT = 3;
    localparam int FL_NMI_BIT = 4;

    // reset values
    localparam logic EN_RST_VAL = 1'b0;
    localparam logic FL_WDOG_POR_VAL = 1'b0;
    localparam logic FL_OSC_PRST_VAL = 1'b1;
    localparam logic FL_POR_POR_VAL = 1'b1;
    localparam logic FL_EXT_POR_VAL = 1'b0;
    localparam logic FL_NMI_PRST_VAL = 1'b0;

    localparam logic [7:0] SIRQ_ZERO_BYTE = 8'h00;

    // watchdog operating mode
    typedef enum logic [0:0] {
        SIRQ_WDOG_RESET = 1'b0,
        SIRQ_WDOG_INTERVAL = 1'b1
    } sirq_wdog_mode_e;
endpackage

// file: rtl/sirq_flag_bit.sv
`timescale 1ns/100ps
// one sticky flag: hardware set wins over a software clear
module sirq_flag_bit #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic wr_in,
    input wire logic wdata_in,
    output logic q_out
);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_out <= RST_VAL;
        end else if (set_in) begin
            q_out <= 1'b1;
        end else if (wr_in) begin
            q_out <= wdata_in;
        end
    end
endmodule

// file: tb/sirq_regs_properties.sv
`timescale 1ns/100ps
// watches the register port and watchdog request; also checks oscillator and power-on flag reads
module sirq_regs_chk (
    input wire logic MCLK_IN, RST_IN, PROGRAM_RESET_IN, POWER_ON_IN,
    input wire logic EXT_PIN_RESET_IN, WR_IN,
    input wire logic [sirq_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic RD_IN, WDOG_MODE_IN, WDOG_INTERVAL_IN, OSC_FAULT_IN,
    input wire logic [sirq_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic WDOG_IRQ_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    idle_read_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data not zero when idle");
    empty_bytes_a: assert property (RD_IN && ADDR_IN != 8'h00 &&
        ADDR_IN != 8'h02 |=> RDATA_OUT == 8'h00)
        else $error("empty byte read nonzero");
    en_unused_a: assert property (RD_IN && ADDR_IN == 8'h00 |=>
        RDATA_OUT[7:6] == 2'b00 && RDATA_OUT[3:2] == 2'b00)
        else $error("unused enable bits set");
    flag_unused_a: assert property (RD_IN && ADDR_IN == 8'h02 |=>
        RDATA_OUT[7:5] == 3'b000)
        else $error("unused flag bits set");
    wdog_gate_a: assert property (WDOG_IRQ_OUT |->
        $past(WDOG_INTERVAL_IN) && $past(WDOG_MODE_IN))
        else $error("watchdog request without interval mode");
    wdog_mode_a: assert property (!WDOG_MODE_IN |=> !WDOG_IRQ_OUT)
        else $error("watchdog request in reset mode");
    osc_sticky_a: assert property (OSC_FAULT_IN ##1 (OSC_FAULT_IN &&
        RD_IN && ADDR_IN == 8'h02) |=> RDATA_OUT[1])
        else $error("oscillator flag clear during fault");
    prst_en_a: assert property (PROGRAM_RESET_IN ##1 !WR_IN ##1 (RD_IN &&
        ADDR_IN == 8'h00) |=> RDATA_OUT == 8'h00)
        else $error("enables kept over program reset");
    pon_flag_a: assert property (POWER_ON_IN ##1
        (!WR_IN && !EXT_PIN_RESET_IN) ##1 (RD_IN &&
        ADDR_IN == 8'h02) |=> RDATA_OUT[3:2] == 2'b01)
        else $error("power-on flags wrong");
endmodule
bind sirq_regs sirq_regs_chk i_chk (
    .MCLK_IN(MCLK_IN),
    .RST_IN(RST_IN),
    .PROGRAM_RESET_IN(PROGRAM_RESET_IN),
    .POWER_ON_IN(POWER_ON_IN),
    .EXT_PIN_RESET_IN(EXT_PIN_RESET_IN),
    .WR_IN(WR_IN),
    .ADDR_IN(ADDR_IN),
    .RD_IN(RD_IN),
    .WDOG_MODE_IN(WDOG_MODE_IN),
    .WDOG_INTERVAL_IN(WDOG_INTERVAL_IN),
    .OSC_FAULT_IN(OSC_FAULT_IN),
    .RDATA_OUT(RDATA_OUT),
    .WDOG_IRQ_OUT(WDOG_IRQ_OUT)
);

// file: tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
err_total++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_top;
    import sirq_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, seen = 0, wirq, nirq;
    logic mode = 0, ivl = 0, osc = 0, fv = 0;
    logic [5:0] pl = 0; // pon, ext, prst, nmi, key, ovf
    logic [7:0] addr = 0, wd = 0, rdata, exp_v, q[$];
    logic [7:0] bad [4] = '{8'h01, 8'h03, 8'h04, 8'hff};
    int err_total = 0, cmp_count = 0;
    logic [31:0] rs = 32'd13965;
    always #4 clk = ~clk;
    sirq_regs i_dut (.MCLK_IN(clk), .RST_IN(rst), .PROGRAM_RESET_IN(pl[3]),
        .POWER_ON_IN(pl[5]), .EXT_PIN_RESET_IN(pl[4]), .ADDR_IN(addr),
        .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .WDOG_MODE_IN(mode), .WDOG_OVERFLOW_IN(pl[0]),
        .WDOG_INTERVAL_IN(ivl), .KEY_VIOLATION_IN(pl[1]),
        .OSC_FAULT_IN(osc), .PIN_NMI_IN(pl[2]), .FLASH_VIOLATION_IN(fv),
        .WDOG_IRQ_OUT(wirq), .NMI_IRQ_OUT(nirq));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // a read carries its expected byte in d
    task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        if (!w) q.push_back(d);
        @(posedge clk);
        wr <= 0;
        rd <= 0;
    endtask
    task automatic pulse(logic [5:0] p);
        @(posedge clk);
        pl <= p;
        @(posedge clk);
        pl <= 0;
    endtask
    task automatic wrap_up();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(negedge clk) begin
        if (seen) begin
            exp_v = q.pop_front();
            `CHK("rdata", exp_v, rdata)
        end
        seen = rd;
    end
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        bus(0, 8'h02, 8'h06);
        for (int i = 0; i < 4; i++) begin
            rs = xs(rs);
            bus(1, 8'h00, rs[7:0]);
            bus(0, 8'h00, rs[7:0] & 8'h33);
        end
        foreach (bad[i]) begin
            bus(1, bad[i], 8'hff);
            bus(0, bad[i], 8'h00);
        end
        bus(1, 8'h02, 8'hff);
        bus(0, 8'h02, 8'h1f);
        bus(1, 8'h02, 8'h00);
        bus(0, 8'h02, 8'h00);
        osc <= 1;
        bus(1, 8'h02, 8'h00);
        bus(0, 8'h02, 8'h02);
        osc <= 0;
        bus(1, 8'h02, 8'h00);
        pulse(6'h01);
        bus(0, 8'h02, 8'h01);
        mode <= 1;
        bus(1, 8'h02, 8'h00);
        pulse(6'h01);
        bus(0, 8'h02, 8'h00);
        pulse(6'h02);
        bus(0, 8'h02, 8'h01);
        pulse(6'h10);
        bus(0, 8'h02, 8'h08);
        bus(1, 8'h00, 8'h33);
        bus(1, 8'h02, 8'h1d);
        pulse(6'h08);
        bus(0, 8'h00, 8'h00);
        bus(0, 8'h02, 8'h0f);
        pulse(6'h20);
        bus(0, 8'h02, 8'h06);
        pulse(6'h04);
        bus(0, 8'h02, 8'h16);
        bus(1, 8'h00, 8'h21);
        ivl <= 1;
        fv <= 1;
        @(posedge clk);
        @(negedge clk);
        `CHK("wdog irq", 1'b1, wirq)
        `CHK("nmi irq", 1'b1, nirq)
        @(posedge clk);
        mode <= 0;
        bus(1, 8'h00, 8'h00);
        @(posedge clk);
        @(negedge clk);
        `CHK("wdog irq", 1'b0, wirq)
        `CHK("nmi irq", 1'b0, nirq)
        bus(1, 8'h00, 8'h02);
        @(posedge clk);
        @(negedge clk);
        `CHK("osc irq", 1'b1, nirq)
        wrap_up();
    end
endmodule
